//--- hdl/psrc_regs.svh
`ifndef PSRC_REGS_SVH
`define PSRC_REGS_SVH
`define PSRC_OUT_W 24
`define PSRC_LO_MSB 11
`define PSRC_HI_LSB 12
`define PSRC_OP_CONT 4'h0
`define PSRC_OP_STOP 4'h1
`define PSRC_OP_WAIT 4'h8
`define PSRC_PC_FIRST 12'h000
`define PSRC_FLAGS_RST 24'h000000
`define PSRC_TRIG_MIN_NS 10
`define PSRC_CLK_NS 25
`define PSRC_TRIG_MIN_CYC ((`PSRC_TRIG_MIN_NS + `PSRC_CLK_NS - 1) / `PSRC_CLK_NS)
`endif

//--- hdl/psrc_pkg.sv
`default_nettype none
package psrc_pkg;
  typedef struct packed {
    logic [3:0] opcode;
    logic [23:0] pattern;
  } psrc_instr_t;
  typedef struct packed {
    logic waiting;
    logic running;
    logic in_reset;
  } psrc_status_t;
endpackage : psrc_pkg
`default_nettype wire

//--- hdl/psrc_run_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "psrc_regs.svh"
module psrc_run_control (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // External restart and fire pins
  input wire logic ext_restart_in_low_active_i,
  input wire logic ext_restart_in_high_active_i,
  input wire logic ext_fire_in_low_active_i,
  input wire logic [1:0] ext_fire_in_high_active_i,
  // Software calls, one-cycle pulses
  input wire logic sw_start_call_i,
  input wire logic sw_reset_call_i,
  // Program step interface
  input wire psrc_pkg::psrc_instr_t instr_i,
  input wire logic instr_done_i,
  output logic [11:0] pc_o,
  // Outputs
  output logic [23:0] flag_out_o,
  output psrc_pkg::psrc_status_t status_o
);
  typedef enum logic [1:0] {PSRC_RESET, PSRC_RUN, PSRC_WAIT, PSRC_STOP}
    psrc_state_t;
  // ------------------------------------------------------------
  // Pin polarity
  // ------------------------------------------------------------
  // Low-active pins are inverted so every lane is active high
  wire restart_low_act = ~ext_restart_in_low_active_i;
  wire fire_low_act = ~ext_fire_in_low_active_i;
  wire [1:0] restart_raw = {ext_restart_in_high_active_i, restart_low_act};
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Lane 0 low-active restart, lane 1 high-active restart
  logic [1:0] restart_sync;
  psrc_sync #(
    .W(2)
  ) u_sync_restart (
    .mclk_i(mclk_i),
    .lane_i(restart_raw),
    .level_o(restart_sync),
    .prev_o()
  );
  // Low-active fire acts on its level, so no older copy is needed
  logic fire_low_sync;
  psrc_sync #(
    .W(1)
  ) u_sync_fire_low (
    .mclk_i(mclk_i),
    .lane_i(fire_low_act),
    .level_o(fire_low_sync),
    .prev_o()
  );
  // Both high-active fire lanes keep an older copy for edge detection
  logic [1:0] fire_high_sync;
  logic [1:0] fire_high_prev;
  psrc_sync #(
    .W(2)
  ) u_sync_fire_high (
    .mclk_i(mclk_i),
    .lane_i(ext_fire_in_high_active_i),
    .level_o(fire_high_sync),
    .prev_o(fire_high_prev)
  );
  // ------------------------------------------------------------
  // Restart decode
  // ------------------------------------------------------------
  // Level, not edge: a held pin keeps the block in reset
  wire restart_low_lvl = restart_sync[0];
  wire restart_high_lvl = restart_sync[1];
  wire restart_lvl = restart_low_lvl | restart_high_lvl;
  // Software reset joins the pins; it is already one clean pulse
  wire hw_restart = restart_lvl | sw_reset_call_i;
  // ------------------------------------------------------------
  // Fire decode
  // ------------------------------------------------------------
  // Held low-active fire repeats; high-active fire on rising edge
  wire fire_low = fire_low_sync;
  wire [1:0] fire_rise = fire_high_sync & ~fire_high_prev;
  wire hw_fire = fire_low | (|fire_rise);
  // Software start and pin fire share one path
  wire go_req = sw_start_call_i | hw_fire;
  // ------------------------------------------------------------
  // State decode
  // ------------------------------------------------------------
  psrc_state_t state;
  psrc_state_t next_state;
  wire st_reset = (state == PSRC_RESET);
  wire st_run = (state == PSRC_RUN);
  wire st_wait = (state == PSRC_WAIT);
  // Triggers count only while the program is idle
  wire idle_go = go_req & (st_reset | st_wait);
  // ------------------------------------------------------------
  // Opcode decode
  // ------------------------------------------------------------
  wire op_stop = (instr_i.opcode == `PSRC_OP_STOP);
  wire op_wait = (instr_i.opcode == `PSRC_OP_WAIT);
  // An instruction only retires while the program runs
  wire step_done = st_run & instr_done_i;
  wire stop_taken = step_done & op_stop;
  wire move_taken = step_done & ~op_stop;
  wire wait_taken = move_taken & op_wait;
  // ------------------------------------------------------------
  // Output pattern groups
  // ------------------------------------------------------------
  // Low group feeds bits 0 to 11, high group bits 12 to 23
  wire [11:0] pat_lo = instr_i.pattern[`PSRC_LO_MSB:0];
  wire [11:0] pat_hi = instr_i.pattern[`PSRC_OUT_W-1:`PSRC_HI_LSB];
  wire [23:0] pat_word = {pat_hi, pat_lo};
  // Next step address; wraps at the top of the program space
  wire [11:0] pc_step = pc_o + 12'h001;
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic [11:0] next_pc;
  logic [23:0] next_flags;
  always_comb begin
    next_state = state;
    next_pc = pc_o;
    next_flags = flag_out_o;
    if (hw_restart) begin
      // Restart wins over every other event
      next_state = PSRC_RESET;
      next_pc = `PSRC_PC_FIRST;
    end else begin
      case (state)
        PSRC_RESET: begin
          if (idle_go) begin
            next_state = PSRC_RUN;
            next_pc = `PSRC_PC_FIRST;
          end
        end
        PSRC_RUN: begin
          if (stop_taken) begin
            // Pattern and counter stay as the last step left them
            next_state = PSRC_STOP;
          end else if (move_taken) begin
            next_flags = pat_word;
            next_pc = pc_step;
            if (wait_taken) begin
              next_state = PSRC_WAIT;
            end
          end
        end
        PSRC_WAIT: begin
          // Counter already points past the wait step
          if (idle_go) begin
            next_state = PSRC_RUN;
          end
        end
        PSRC_STOP: begin
          // Needs a reset first; trigger ignored here
          next_state = PSRC_STOP;
        end
        default: begin
          next_state = PSRC_RESET;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= PSRC_RESET;
      pc_o <= `PSRC_PC_FIRST;
      flag_out_o <= `PSRC_FLAGS_RST;
    end else begin
      state <= next_state;
      pc_o <= next_pc;
      flag_out_o <= next_flags;
    end
  end
  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  // Flag 24 reset, flag 25 running, flag 26 waiting
  always_comb begin
    status_o.in_reset = st_reset;
    status_o.running = st_run | st_wait;
    status_o.waiting = st_wait;
  end
endmodule : psrc_run_control
// ------------------------------------------------------------
// Two-flop synchroniser with an older copy for edge detection
// ------------------------------------------------------------
module psrc_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic mclk_i,
  // Asynchronous lanes, already active high
  input wire logic [W-1:0] lane_i,
  // Synchronised level and its copy one clock older
  output logic [W-1:0] level_o,
  output logic [W-1:0] prev_o
);
  logic [W-1:0] meta;
  always_ff @(posedge mclk_i) begin
    meta <= lane_i;
    level_o <= meta;
    prev_o <= level_o;
  end
endmodule : psrc_sync
`default_nettype wire

//--- bench/psrc_props.sv
`timescale 1ns/1ps
`default_nettype none
module psrc_props (
  input wire logic mclk_i, srst_i, sw_reset_call_i, instr_done_i,
  input wire logic ext_restart_in_low_active_i, ext_fire_in_low_active_i,
  input wire psrc_pkg::psrc_instr_t instr_i,
  input wire logic [11:0] pc_o,
  input wire logic [23:0] flag_out_o,
  input wire psrc_pkg::psrc_status_t status_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire logic st = instr_done_i & status_o.running & ~status_o.waiting
    & ~sw_reset_call_i;
  chk_wait_run: assert property (status_o.waiting |-> status_o.running)
    else $error("wait no run");
  chk_reset_idle: assert property (status_o.in_reset |-> !status_o.running)
    else $error("run in reset");
  chk_sw_reset: assert property (sw_reset_call_i |=> status_o.in_reset)
    else $error("sw reset");
  chk_start_pc: assert property ($rose(status_o.running) &&
    $past(status_o.in_reset) |-> pc_o == 12'h000) else $error("start pc");
  chk_wait_op: assert property (st && instr_i.opcode == 4'h8 |=>
    status_o.waiting && pc_o == $past(pc_o) + 12'h001) else $error("wait");
  chk_stop_op: assert property (st && instr_i.opcode == 4'h1 |=>
    !status_o.running && $stable(flag_out_o)) else $error("stop");
  chk_fire_go: assert property ($fell(ext_fire_in_low_active_i) &&
    status_o.waiting |-> ##[2:4] !status_o.waiting) else $error("resume");
  chk_ext_restart_in_low_active: assert property (!ext_restart_in_low_active_i [*2]
    |-> ##[1:3] status_o.in_reset) else $error("ext_restart_in_low_active");
  cover property (status_o.waiting);
  cover property ($fell(status_o.running) && !status_o.in_reset);
  cover property ($rose(status_o.in_reset));
endmodule : psrc_props
bind psrc_run_control psrc_props u_props (.*);
`default_nettype wire

//--- bench/psrc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module psrc_far_end (
  output wire logic [4:0] pins_o
);
  logic [4:0] pins = 5'h09;
  assign pins_o = pins;
  task automatic pulse(input int b, input int n);
    pins[b] = ~pins[b];
    #(25 * n) pins[b] = ~pins[b];
  endtask : pulse
endmodule : psrc_far_end
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i = 0, srst_i = 1, ss = 0, sr = 0, dn = 0;
  wire logic [4:0] p;
  logic [11:0] pc;
  logic [23:0] fl;
  psrc_pkg::psrc_status_t s;
  psrc_pkg::psrc_instr_t pg [4] = '{28'h8A5A5A5, 28'h15A5A5A, 28'h0, 28'h0};
  int fails = 0, n_tests = 0, cyc = 0;
  psrc_far_end far (.pins_o(p));
  psrc_run_control uut (.mclk_i(mclk_i), .srst_i(srst_i),
    .ext_restart_in_low_active_i(p[3]), .ext_restart_in_high_active_i(p[4]),
    .ext_fire_in_low_active_i(p[0]), .ext_fire_in_high_active_i(p[2:1]),
    .sw_start_call_i(ss), .sw_reset_call_i(sr), .instr_i(pg[pc[1:0]]),
    .instr_done_i(dn), .pc_o(pc), .flag_out_o(fl), .status_o(s));
  initial forever #12.5 mclk_i = ~mclk_i;
  task automatic give_verdict;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : tick
  task automatic t_run;
    chk("st", 24'h1, 24'(s));
    ss = 1; tick(1); ss = 0;
    chk("st", 24'h2, 24'(s));
    chk("pc", 24'h0, 24'(pc));
    dn = 1; tick(1); dn = 0;
    chk("st", 24'h6, 24'(s));
    chk("fl", 24'hA5A5A5, fl);
    far.pulse(0, 1); tick(5);
    chk("st", 24'h2, 24'(s));
    chk("pc", 24'h1, 24'(pc));
  endtask : t_run
  task automatic t_stop;
    dn = 1; tick(1); dn = 0;
    chk("st", 24'h0, 24'(s));
    chk("fl", 24'hA5A5A5, fl);
    far.pulse(1, 1); tick(5);
    chk("st", 24'h0, 24'(s));
    far.pulse(4, 1); tick(5);
    chk("st", 24'h1, 24'(s));
    chk("pc", 24'h0, 24'(pc));
    far.pulse(2, 1); tick(5);
    chk("st", 24'h2, 24'(s));
    chk("pc", 24'h0, 24'(pc));
  endtask : t_stop
  task automatic t_hold;
    fork
      far.pulse(3, 8);
      begin
        tick(4); ss = 1; tick(1); ss = 0;
        chk("st", 24'h1, 24'(s));
      end
    join
    tick(5);
    chk("st", 24'h1, 24'(s));
    ss = 1; tick(1); ss = 0;
    chk("st", 24'h2, 24'(s));
    sr = 1; tick(1); sr = 0;
    chk("st", 24'h1, 24'(s));
    far.pulse(1, 1); tick(5);
    chk("st", 24'h2, 24'(s));
  endtask : t_hold
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    tick(12); srst_i = 0;
    t_run; t_stop; t_hold;
    give_verdict;
  end
endmodule : tb
`default_nettype wire
